// ==== tpwm_pkg.sv ====
// constants and types for the one-pulse / pwm timer block
package tpwm_pkg;
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_RESET = 16'hfffc;      // counter value after reset
  localparam logic [15:0] RELOAD_VAL = 16'hfffc;     // reload on trigger or period end
  localparam logic [15:0] OPM_CAPTURE_VAL = 16'hfffd; // capture one value on trigger
  localparam logic [15:0] CMP_RESET = 16'h8000;      // compare registers after reset
  localparam int unsigned PULSE_EXTRA_TICKS = 5;     // counts added to compare value
  // clock select codes
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [2:0] PRESCALE_FACTOR_MAX = 3'h7;
  // operating modes
  typedef enum logic [2:0] {
    TPWM_MODE_FREE = 3'b001,
    TPWM_MODE_OPM  = 3'b010,
    TPWM_MODE_PWM  = 3'b100
  } tpwm_mode_t;
endpackage : tpwm_pkg

// ==== tpwm_sync.sv ====
// two-stage synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
`default_nettype none
module tpwm_sync (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // pin and selected edge
  input  wire logic pin_i,
  input  wire logic rise_sel_i,
  output logic      level_o,
  output logic      edge_o
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_last;

  // next values of the chain
  always_comb
  begin
    nxt_meta = pin_i;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  // register the chain
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  // edge from the second and third stages only
  assign level_o = sync_ff;
  assign edge_o  = rise_sel_i ? (sync_ff & ~last_ff) : (~sync_ff & last_ff);
endmodule : tpwm_sync
`default_nettype wire

// ==== tpwm_prescale_factor.sv ====
// prescaler: one-cycle timer tick from cpu clock divider or external edge
`timescale 1ns/1ps
`default_nettype none
module tpwm_prescale_factor (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       run_i,
  input  wire logic [1:0] timer_clock_select_i,
  input  wire logic       ext_edge_i,
  output logic            tick_o
);
  logic [2:0] div_ff;
  logic [2:0] nxt_div;
  logic [2:0] mask;

  // prescale_factor: mask selects divide by 2, 4 or 8
  always_comb
  begin
    unique case (timer_clock_select_i)
      tpwm_pkg::CLK_DIV2: mask = 3'h1;
      tpwm_pkg::CLK_DIV4: mask = 3'h3;
      tpwm_pkg::CLK_DIV8: mask = 3'h7;
      default:            mask = 3'h0;
    endcase
    nxt_div = run_i ? div_ff + 3'h1 : div_ff;
    if (run_i && (div_ff == tpwm_pkg::PRESCALE_FACTOR_MAX))
      nxt_div = 3'h0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_ff <= 3'h0;
    else
      div_ff <= nxt_div;
  end

  // tick when masked divider bits are all ones, or on external edge
  assign tick_o = run_i & ((timer_clock_select_i == tpwm_pkg::CLK_EXT) ? ext_edge_i :
                  ((div_ff & mask) == mask));
endmodule : tpwm_prescale_factor
`default_nettype wire

// ==== tpwm_timer.sv ====
// 16-bit timer core with one-pulse and pwm operation
`timescale 1ns/1ps
`default_nettype none
module tpwm_timer (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // pins
  input  wire logic        capture_input_first_i,
  input  wire logic        capture_input_second_i,
  input  wire logic        ext_clock_i,
  output logic             compare_output_first_o,
  output logic             compare_output_first_oe_o,
  // control one
  input  wire logic        capture_irq_enable_i,
  input  wire logic        match_irq_enable_i,
  input  wire logic        overflow_irq_enable_i,
  input  wire logic        level_bit_first_i,
  input  wire logic        level_bit_second_i,
  input  wire logic        capture_one_edge_select_i,
  // control two
  input  wire logic        compare_pin_first_enable_i,
  input  wire logic        one_pulse_select_i,
  input  wire logic        pwm_select_i,
  input  wire logic [1:0]  timer_clock_select_i,
  input  wire logic        capture_two_edge_select_i,
  input  wire logic        ext_clock_edge_select_i,
  // compare writes, one-cycle strobes
  input  wire logic [1:0]  compare_high_byte_wr_i,
  input  wire logic [1:0]  compare_low_byte_wr_i,
  input  wire logic [7:0]  compare_wdata_i,
  // flag clearing accesses, one-cycle strobes
  input  wire logic        status_rd_i,
  input  wire logic [1:0]  capture_low_byte_acc_i,
  input  wire logic [1:0]  compare_low_byte_acc_i,
  input  wire logic        counter_low_byte_acc_i,
  // power state and cpu mask
  input  wire logic        halt_i,
  input  wire logic        wait_i,
  input  wire logic        cpu_irq_mask_i,
  // status
  output logic [15:0]      counter_o,
  output logic [15:0]      capture_value_one_o,
  output logic [15:0]      capture_value_two_o,
  output logic [15:0]      compare_value_one_o,
  output logic [15:0]      compare_value_two_o,
  output logic [7:0]       timer_status_reg_o,
  output logic             timer_irq_o,
  output logic             wake_req_o
);
  // counter, capture and compare state
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [15:0] cap1_ff;
  logic [15:0] nxt_cap1;
  logic [15:0] cap2_ff;
  logic [15:0] nxt_cap2;
  logic [15:0] cmp_ff [2];
  logic [15:0] nxt_cmp [2];
  logic [1:0]  inh_ff;       // compare held off after a high-byte write
  logic [1:0]  nxt_inh;
  // flags and their clear arming
  logic        capture_flag_first_ff;
  logic        nxt_capture_flag_first;
  logic        capture_flag_second_ff;
  logic        nxt_capture_flag_second;
  logic        match_flag_first_ff;
  logic        nxt_match_flag_first;
  logic        match_flag_second_ff;
  logic        nxt_match_flag_second;
  logic        tof_ff;
  logic        nxt_tof;
  logic [4:0]  armed_ff;     // status-read arm per flag
  logic [4:0]  nxt_armed;
  logic [1:0]  halt_arm_ff;
  logic [1:0]  nxt_halt_arm;
  logic        halt_last_ff;
  // output pin, interrupt and wake
  logic        out_ff;
  logic        nxt_out;
  logic        oe_ff;
  logic        irq_ff;
  logic        nxt_irq;
  logic        wake_ff;
  // events computed each cycle
  logic        ic1_edge;
  logic        ic2_edge;
  logic        ext_edge;
  logic        tick;
  logic        halt_exit;
  logic        match1;
  logic        match2;
  logic        trig;
  logic        rel;
  logic        cap1_ev;
  logic        cap2_ev;
  tpwm_pkg::tpwm_mode_t mode;

  // pin synchronisers
  tpwm_sync u_sync_ic1 (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .pin_i(capture_input_first_i), .rise_sel_i(capture_one_edge_select_i),
    .level_o(), .edge_o(ic1_edge));
  tpwm_sync u_sync_ic2 (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .pin_i(capture_input_second_i), .rise_sel_i(capture_two_edge_select_i),
    .level_o(), .edge_o(ic2_edge));
  tpwm_sync u_sync_ext (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .pin_i(ext_clock_i), .rise_sel_i(ext_clock_edge_select_i),
    .level_o(), .edge_o(ext_edge));

  // timer tick; halt freezes the prescaler and counter
  tpwm_prescale_factor u_prescale_factor (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .run_i(~halt_i),
    .timer_clock_select_i(timer_clock_select_i), .ext_edge_i(ext_edge), .tick_o(tick));

  // mode decode: pwm wins over one-pulse
  always_comb
  begin
    if (pwm_select_i)
      mode = tpwm_pkg::TPWM_MODE_PWM;
    else if (one_pulse_select_i)
      mode = tpwm_pkg::TPWM_MODE_OPM;
    else
      mode = tpwm_pkg::TPWM_MODE_FREE;
  end

  // events
  assign halt_exit = halt_last_ff & ~halt_i;
  assign match1 = tick & ~inh_ff[0] & (cnt_ff == cmp_ff[0]);
  assign match2 = tick & ~inh_ff[1] & (cnt_ff == cmp_ff[1]);
  assign trig = ~halt_i & ic1_edge & (mode == tpwm_pkg::TPWM_MODE_OPM);
  assign rel = trig | (match2 & (mode == tpwm_pkg::TPWM_MODE_PWM));
  // capture one only outside pulse modes; capture two always
  assign cap1_ev = (mode == tpwm_pkg::TPWM_MODE_FREE) &
                   ((ic1_edge & ~halt_i) | (halt_exit & halt_arm_ff[0]));
  assign cap2_ev = (ic2_edge & ~halt_i) | (halt_exit & halt_arm_ff[1]);

  // counter, compare registers and capture registers
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (rel)
      nxt_cnt = tpwm_pkg::RELOAD_VAL;
    else if (tick)
      nxt_cnt = cnt_ff + 16'h0001;
    nxt_cap1 = cap1_ff;
    if (trig)
      nxt_cap1 = tpwm_pkg::OPM_CAPTURE_VAL;
    else if (cap1_ev)
      nxt_cap1 = cnt_ff;
    nxt_cap2 = cap2_ev ? cnt_ff : cap2_ff;
    for (int i = 0; i < 2; i++)
    begin
      nxt_cmp[i] = cmp_ff[i];
      nxt_inh[i] = inh_ff[i];
      if (compare_high_byte_wr_i[i])
      begin
        nxt_cmp[i][15:8] = compare_wdata_i;
        nxt_inh[i] = 1'b1;
      end
      if (compare_low_byte_wr_i[i])
      begin
        nxt_cmp[i][7:0] = compare_wdata_i;
        nxt_inh[i] = 1'b0;
      end
    end
  end

  // halt capture arming
  always_comb
  begin
    nxt_halt_arm = halt_arm_ff;
    if (halt_exit)
      nxt_halt_arm = 2'h0;
    if (halt_i)
      nxt_halt_arm = halt_arm_ff | {ic2_edge, ic1_edge};
  end

  // flags: set wins over clear; clear needs prior status read while set
  always_comb
  begin
    logic [4:0] flags;
    logic [4:0] acc;
    flags = {capture_flag_first_ff, match_flag_first_ff, tof_ff, capture_flag_second_ff, match_flag_second_ff};
    acc = {capture_low_byte_acc_i[0], compare_low_byte_acc_i[0], counter_low_byte_acc_i,
           capture_low_byte_acc_i[1], compare_low_byte_acc_i[1]};
    nxt_armed = armed_ff;
    if (status_rd_i)
      nxt_armed = armed_ff | flags;
    nxt_capture_flag_first = (capture_flag_first_ff & ~(armed_ff[4] & acc[4])) | trig | cap1_ev
               | (match2 & (mode == tpwm_pkg::TPWM_MODE_PWM));
    nxt_match_flag_first = (match_flag_first_ff & ~(armed_ff[3] & acc[3]))
               | (match1 & (mode == tpwm_pkg::TPWM_MODE_FREE));
    nxt_tof = (tof_ff & ~(armed_ff[2] & acc[2])) | (tick & ~rel & (cnt_ff == 16'hffff));
    nxt_capture_flag_second = (capture_flag_second_ff & ~(armed_ff[1] & acc[1])) | cap2_ev;
    nxt_match_flag_second = (match_flag_second_ff & ~(armed_ff[0] & acc[0]))
               | (match2 & (mode != tpwm_pkg::TPWM_MODE_PWM));
    for (int k = 0; k < 5; k++)
      if (acc[k])
        nxt_armed[k] = 1'b0;
    // shared interrupt, gated per group and by the cpu mask
    nxt_irq = ~cpu_irq_mask_i &
              ((capture_irq_enable_i & (nxt_capture_flag_first | nxt_capture_flag_second))
             | (match_irq_enable_i & (nxt_match_flag_first | nxt_match_flag_second))
             | (overflow_irq_enable_i & nxt_tof));
  end

  // compare output one waveform
  always_comb
  begin
    nxt_out = out_ff;
    unique case (mode)
      tpwm_pkg::TPWM_MODE_OPM:
      begin
        if (trig)
          nxt_out = level_bit_second_i;
        else if (match1)
          nxt_out = level_bit_first_i;
      end
      tpwm_pkg::TPWM_MODE_PWM:
      begin
        if (match2)
          nxt_out = level_bit_second_i;
        else if (match1)
          nxt_out = level_bit_first_i;
      end
      tpwm_pkg::TPWM_MODE_FREE:
      begin
        if (match1)
          nxt_out = level_bit_first_i;
      end
    endcase
  end

  // register all state
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff       <= tpwm_pkg::CNT_RESET;
      cap1_ff      <= 16'h0000;
      cap2_ff      <= 16'h0000;
      cmp_ff[0]    <= tpwm_pkg::CMP_RESET;
      cmp_ff[1]    <= tpwm_pkg::CMP_RESET;
      inh_ff       <= 2'h0;
      capture_flag_first_ff      <= 1'b0;
      match_flag_first_ff      <= 1'b0;
      tof_ff       <= 1'b0;
      capture_flag_second_ff      <= 1'b0;
      match_flag_second_ff      <= 1'b0;
      armed_ff     <= 5'h00;
      halt_arm_ff  <= 2'h0;
      halt_last_ff <= 1'b0;
      out_ff       <= 1'b0;
      oe_ff        <= 1'b0;
      irq_ff       <= 1'b0;
      wake_ff      <= 1'b0;
    end
    else
    begin
      cnt_ff       <= nxt_cnt;
      cap1_ff      <= nxt_cap1;
      cap2_ff      <= nxt_cap2;
      cmp_ff[0]    <= nxt_cmp[0];
      cmp_ff[1]    <= nxt_cmp[1];
      inh_ff       <= nxt_inh;
      capture_flag_first_ff      <= nxt_capture_flag_first;
      match_flag_first_ff      <= nxt_match_flag_first;
      tof_ff       <= nxt_tof;
      capture_flag_second_ff      <= nxt_capture_flag_second;
      match_flag_second_ff      <= nxt_match_flag_second;
      armed_ff     <= nxt_armed;
      halt_arm_ff  <= nxt_halt_arm;
      halt_last_ff <= halt_i;
      out_ff       <= nxt_out;
      oe_ff        <= compare_pin_first_enable_i;
      irq_ff       <= nxt_irq;
      wake_ff      <= nxt_irq & wait_i & ~halt_i;
    end
  end

  // outputs straight from flip-flops
  assign compare_output_first_o    = out_ff;
  assign compare_output_first_oe_o = oe_ff;
  assign counter_o            = cnt_ff;
  assign capture_value_one_o  = cap1_ff;
  assign capture_value_two_o  = cap2_ff;
  assign compare_value_one_o  = cmp_ff[0];
  assign compare_value_two_o  = cmp_ff[1];
  assign timer_status_reg_o   = {capture_flag_first_ff, match_flag_first_ff, tof_ff, capture_flag_second_ff, match_flag_second_ff, 3'h0};
  assign timer_irq_o          = irq_ff;
  assign wake_req_o           = wake_ff;
endmodule : tpwm_timer
`default_nettype wire

// ==== tpwm_timer_asserts.sv ====
// port assertions for the one-pulse / pwm timer
`timescale 1ns/1ps
`default_nettype none
module tpwm_timer_asserts (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  // controls
  input wire logic        one_pulse_select_i,
  input wire logic        pwm_select_i,
  input wire logic        level_bit_first_i,
  input wire logic        level_bit_second_i,
  input wire logic        capture_irq_enable_i,
  input wire logic        match_irq_enable_i,
  input wire logic        overflow_irq_enable_i,
  input wire logic        halt_i,
  input wire logic        wait_i,
  input wire logic        cpu_irq_mask_i,
  // observed state
  input wire logic        compare_output_first_o,
  input wire logic [15:0] counter_o,
  input wire logic [15:0] capture_value_one_o,
  input wire logic [15:0] compare_value_one_o,
  input wire logic [15:0] compare_value_two_o,
  input wire logic [7:0]  timer_status_reg_o,
  input wire logic        timer_irq_o,
  input wire logic        wake_req_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // the counter moved while a pulse operation was selected
  sequence s_tick_step;
    $changed(counter_o) && $past(one_pulse_select_i || pwm_select_i);
  endsequence
  // the count just left compare two in pwm operation
  sequence s_period_end;
    s_tick_step ##0 $past(pwm_select_i) && $past(counter_o) == $past(compare_value_two_o);
  endsequence
  // period end: reload, flag one, level two
  a_pwm_reload: assert property (s_period_end |-> counter_o == 16'hfffc)
    else $error("period end did not reload");
  a_pwm_period_flag: assert property (s_period_end |-> timer_status_reg_o[7])
    else $error("period end did not set capture flag one");
  a_pwm_period_level: assert property (
    s_period_end |-> compare_output_first_o == $past(level_bit_second_i))
    else $error("period end did not drive level two");
  // compare one match drives level one
  a_cmp_one_level: assert property (
    s_tick_step ##0 $past(counter_o) == $past(compare_value_one_o) && counter_o != 16'hfffc
    |-> compare_output_first_o == $past(level_bit_first_i))
    else $error("compare one match did not drive level one");
  a_opm_trigger: assert property (
    $changed(capture_value_one_o) && $past(one_pulse_select_i && !pwm_select_i)
    |-> capture_value_one_o == 16'hfffd && counter_o == 16'hfffc && timer_status_reg_o[7]
    && compare_output_first_o == $past(level_bit_second_i))
    else $error("trigger load incomplete");
  a_no_match_one: assert property ($rose(timer_status_reg_o[6])
    |-> !$past(one_pulse_select_i || pwm_select_i))
    else $error("match flag one set in pulse operation");
  a_pwm_no_match: assert property ($rose(timer_status_reg_o[3]) |-> !$past(pwm_select_i))
    else $error("match flag two set in pwm");
  a_equal_levels: assert property (
    $changed(compare_output_first_o) && $past(level_bit_first_i == level_bit_second_i)
    && $past(one_pulse_select_i || pwm_select_i) |-> compare_output_first_o == $past(level_bit_first_i))
    else $error("output left the common level");
  a_halt_freeze: assert property (
    $past(halt_i) && $past(halt_i, 2) && $past(halt_i, 3) |-> $stable(counter_o))
    else $error("counter moved in halt");
  a_irq_gate: assert property (timer_irq_o |-> !$past(cpu_irq_mask_i) &&
    ($past(capture_irq_enable_i) && (timer_status_reg_o[7] || timer_status_reg_o[4])
    || $past(match_irq_enable_i) && (timer_status_reg_o[6] || timer_status_reg_o[3])
    || $past(overflow_irq_enable_i) && timer_status_reg_o[5]))
    else $error("irq without enabled flag");
  a_wake_gate: assert property (wake_req_o |-> $past(wait_i) && !$past(halt_i))
    else $error("wake outside wait");
endmodule : tpwm_timer_asserts
bind tpwm_timer tpwm_timer_asserts u_asserts (
  .clk_sys_i, .rst_n_i, .one_pulse_select_i, .pwm_select_i, .level_bit_first_i,
  .level_bit_second_i, .capture_irq_enable_i, .match_irq_enable_i, .overflow_irq_enable_i,
  .halt_i, .wait_i, .cpu_irq_mask_i, .compare_output_first_o, .counter_o,
  .capture_value_one_o, .compare_value_one_o, .compare_value_two_o, .timer_status_reg_o,
  .timer_irq_o, .wake_req_o);
`default_nettype wire

// ==== tpwm_partner.sv ====
// trigger source and waveform load for the timer
`timescale 1ns/1ps
`default_nettype none
module tpwm_partner (
  // clock and reset
  input  wire logic   clk_sys_i,
  input  wire logic   rst_n_i,
  // trigger request and waveform
  input  wire logic   fire_i,
  input  wire logic   wave_i,
  input  wire logic   wave_oe_i,
  output logic        trig_o,
  output logic [15:0] high_cnt_o
);
  logic wave_ff;
  // pin follows the request, idle low; load counts the cycles of the latest driven high pulse
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trig_o     <= 1'b0;
      wave_ff    <= 1'b0;
      high_cnt_o <= 16'h0000;
    end
    else
    begin
      trig_o  <= fire_i;
      wave_ff <= wave_i;
      if (wave_i && wave_oe_i)
        high_cnt_o <= wave_ff ? high_cnt_o + 16'h0001 : 16'h0001;
    end
  end
endmodule : tpwm_partner
`default_nettype wire

// ==== timer_one_pulse_pwm_modes_test.sv ====
// self-checking bench for the one-pulse / pwm timer
`timescale 1ns/1ps
`default_nettype none
module timer_one_pulse_pwm_modes_test;
  logic        clk, rst_n, cap1, cap2, cap_en, match_en, ovf_en, l1, l2, e1sel, pin_en;
  logic        one_pulse_select, pwm, wt, halt, mask, srd, fire, out, oe, irq, wake, ext;
  logic [1:0]  csel, hwr, lwr, capacc;
  logic [7:0]  wdata, st;
  logic [15:0] cnt, cap1v, cap2v, cmp1v, cmp2v, hcnt;
  int          fail_count, num_checks;
  // 10 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // design and far-side model
  tpwm_timer DUT (.clk_sys_i(clk), .rst_n_i(rst_n), .capture_input_first_i(cap1),
    .capture_input_second_i(cap2), .ext_clock_i(ext), .compare_output_first_o(out),
    .compare_output_first_oe_o(oe), .capture_irq_enable_i(cap_en), .match_irq_enable_i(match_en),
    .overflow_irq_enable_i(ovf_en), .level_bit_first_i(l1), .level_bit_second_i(l2),
    .capture_one_edge_select_i(e1sel), .compare_pin_first_enable_i(pin_en),
    .one_pulse_select_i(one_pulse_select), .pwm_select_i(pwm), .timer_clock_select_i(csel),
    .capture_two_edge_select_i(1'b1), .ext_clock_edge_select_i(1'b1),
    .compare_high_byte_wr_i(hwr), .compare_low_byte_wr_i(lwr), .compare_wdata_i(wdata),
    .status_rd_i(srd), .capture_low_byte_acc_i(capacc), .compare_low_byte_acc_i(2'h0),
    .counter_low_byte_acc_i(1'b0), .halt_i(halt), .wait_i(wt), .cpu_irq_mask_i(mask),
    .counter_o(cnt), .capture_value_one_o(cap1v), .capture_value_two_o(cap2v),
    .compare_value_one_o(cmp1v), .compare_value_two_o(cmp2v), .timer_status_reg_o(st),
    .timer_irq_o(irq), .wake_req_o(wake));
  tpwm_partner u_partner (.clk_sys_i(clk), .rst_n_i(rst_n), .fire_i(fire), .wave_i(out),
    .wave_oe_i(oe), .trig_o(cap1), .high_cnt_o(hcnt));
  // counted comparison
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok)
    begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // high byte then low byte, compare inhibited between
  task automatic wr_cmp(input int i, input logic [15:0] v);
    @(posedge clk) hwr[i] <= 1'b1;
    wdata <= v[15:8];
    @(posedge clk) hwr[i] <= 1'b0;
    lwr[i] <= 1'b1;
    wdata <= v[7:0];
    @(posedge clk) lwr[i] <= 1'b0;
  endtask : wr_cmp
  task automatic wait_out(input logic lvl);
    int n;
    for (n = 0; out !== lvl && n < 400; n++) @(negedge clk);
    chk(n < 400, "output level not reached");
  endtask : wait_out
  task automatic t_clock_select();
    logic [1:0]  code [3] = '{tpwm_pkg::CLK_DIV4, tpwm_pkg::CLK_DIV2, tpwm_pkg::CLK_DIV8};
    int          exp [3] = '{20, 40, 10};
    logic [15:0] c0;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk) csel <= code[k];
      cyc(10);
      c0 = cnt;
      cyc(80);
      chk(cnt - c0 === 16'(exp[k]), "tick rate");
    end
    // external clock: six rising edges give six ticks
    @(posedge clk) csel <= tpwm_pkg::CLK_EXT;
    cyc(3);
    c0 = cnt;
    repeat (12) @(posedge clk) ext <= ~ext;
    cyc(6);
    chk(cnt - c0 === 16'h0006, "external clock rate");
    @(posedge clk) csel <= tpwm_pkg::CLK_DIV8;
    $display("clock select test done");
  endtask : t_clock_select
  task automatic t_halt();
    logic [15:0] c0;
    @(posedge clk) halt <= 1'b1;
    cyc(5);
    c0 = cnt;
    // capture two edge while halted only arms the channel
    @(posedge clk) cap2 <= 1'b1;
    cyc(40);
    chk(cnt === c0 && st[4] === 1'b0, "counter moved or flag set in halt");
    @(posedge clk) halt <= 1'b0;
    cap2 <= 1'b0;
    cyc(20);
    chk(cnt !== c0 && cnt - c0 < 16'h0004, "no resume from held count");
    chk(cap2v === c0 && st[4] === 1'b1, "armed capture not taken at exit");
    @(posedge clk) srd <= 1'b1;
    @(posedge clk) srd <= 1'b0;
    capacc <= 2'h2;
    @(posedge clk) capacc <= 2'h0;
    cyc(1);
    chk(st[4] === 1'b0, "capture flag two not cleared");
    $display("halt test done");
  endtask : t_halt
  task automatic t_opm();
    wr_cmp(0, 16'h0004);
    @(posedge clk) csel <= tpwm_pkg::CLK_DIV2;
    {l2, e1sel, pin_en, cap_en, wt, one_pulse_select} <= 6'h3f;
    cyc(4);
    @(posedge clk) fire <= 1'b1;
    wait_out(1'b1);
    chk(cap1v === 16'hfffd && st[7] === 1'b1, "trigger load");
    cyc(2);
    chk(irq === 1'b1 && wake === 1'b1, "irq or wake missing");
    wait_out(1'b0);
    chk(hcnt >= 16'h0011 && hcnt <= 16'h0012, "pulse length");
    chk(st[6] === 1'b0, "match flag one set");
    @(posedge clk) fire <= 1'b0;
    wt <= 1'b0;
    cyc(8);
    chk(out === 1'b0, "wrong edge triggered");
    // falling select: rising edge ignored, falling edge fires
    @(posedge clk) e1sel <= 1'b0;
    fire <= 1'b1;
    cyc(8);
    chk(out === 1'b0, "rising edge taken with falling select");
    @(posedge clk) fire <= 1'b0;
    wait_out(1'b1);
    wait_out(1'b0);
    @(posedge clk) e1sel <= 1'b1;
    $display("one pulse test done");
  endtask : t_opm
  task automatic t_pwm();
    wr_cmp(0, 16'h0002);
    wr_cmp(1, 16'h0006);
    @(posedge clk) {l1, l2, fire} <= 3'h5;
    cyc(6);
    @(posedge clk) pwm <= 1'b1;
    wait_out(1'b1);
    chk(cmp1v === 16'h0002 && cmp2v === 16'h0006, "compare write");
    @(posedge clk) fire <= 1'b0;
    wait_out(1'b0);
    chk(hcnt === 16'h0008 && st[6] === 1'b0 && st[3] === 1'b0, "pwm high time");
    @(posedge clk) capacc <= 2'h1;
    @(posedge clk) capacc <= 2'h0;
    cyc(1);
    chk(st[7] === 1'b1, "cleared without status read");
    @(posedge clk) srd <= 1'b1;
    @(posedge clk) srd <= 1'b0;
    capacc <= 2'h1;
    @(posedge clk) capacc <= 2'h0;
    cyc(1);
    chk(st[7] === 1'b0, "flag not cleared");
    @(posedge clk) {cap2, cap_en, match_en} <= 3'h5;
    wait_out(1'b1);
    @(posedge clk) fire <= 1'b1;
    wait_out(1'b0);
    chk(hcnt === 16'h0008 && cap1v === 16'hfffd, "trigger reached pwm");
    chk(st[7] === 1'b1 && st[4] === 1'b1 && irq === 1'b0, "flags or gating");
    @(posedge clk) ovf_en <= 1'b1;
    cyc(3);
    chk(irq === 1'b1, "overflow irq missing");
    @(posedge clk) mask <= 1'b1;
    cyc(3);
    chk(irq === 1'b0, "masked irq raised");
    @(posedge clk) {mask, ovf_en} <= 2'h0;
    $display("pwm test done");
  endtask : t_pwm
  task automatic t_equal();
    @(posedge clk) l2 <= 1'b1;
    wait_out(1'b1);
    for (int k = 0; k < 40; k++)
    begin
      cyc(1);
      chk(out === 1'b1, "output moved with equal levels");
    end
    $display("equal level test done");
  endtask : t_equal
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // main sequence
  initial
  begin
    {rst_n, cap2, cap_en, match_en, ovf_en, l1, l2, e1sel, pin_en, one_pulse_select, pwm} = '0;
    {wt, halt, mask, srd, fire, ext, csel, hwr, lwr, capacc, wdata} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_clock_select();
    t_halt();
    t_opm();
    t_pwm();
    t_equal();
    final_report();
  end
  // hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule : timer_one_pulse_pwm_modes_test
`default_nettype wire
